//--- periph_drive_model.sv
// ****************************************
// peripheral side drive model
// ****************************************
module periph_drive_model (
    input wire logic clk_i, // system clock
    input wire logic shuffle_i, // draw new drive values
    output logic [31:0] led_seg_o, // segment drive
    output logic [15:0] led_dig_o, // digit drive
    output logic [7:0] led_com_o, // common drive
    output logic [7:0] led_dseg_o, // d-segment drive
    output logic [7:0] spi_o, // mosi, miso, sck, select: value then enable
    output logic [5:0] cc_out_o, // capture/compare values
    output logic [5:0] cc_oe_o, // capture/compare enables
    output logic [6:0] misc_o, // buzzer, pwm a/b, uart b/c/d tx, clock out
    output logic [15:0] gpio_out_o, // gpio values
    output logic [15:0] gpio_oe_o, // gpio enables
    output logic analog_o // analog enable of the filter pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] spare;
    // values hold between draws so a routed pin can be compared at leisure
    initial begin
        {led_seg_o, led_dig_o, led_com_o, led_dseg_o, gpio_out_o, gpio_oe_o} = '0;
        {spi_o, cc_out_o, cc_oe_o, misc_o, analog_o, spare} = '0;
    end
    always @(posedge clk_i) begin
        if (shuffle_i) begin
            led_seg_o <= $urandom;
            {led_dig_o, led_com_o, led_dseg_o} <= $urandom;
            {gpio_out_o, gpio_oe_o} <= $urandom;
            {spi_o, cc_out_o, cc_oe_o, misc_o, spare} <= $urandom;
            // software may leave the analog enable off; alternate it so both cases occur
            analog_o <= ~analog_o;
        end
    end
endmodule // periph_drive_model

//--- pin_func_checker.sv
// ****************************************
// bus and analog pin checks
// ****************************************
module pin_func_checker
    import pin_func_pkg::*;
(
    input wire logic clk_i, // clock
    input wire logic rst_i, // reset
    input wire logic cyc_i, // cycle
    input wire logic stb_i, // strobe
    input wire logic we_i, // write
    input wire logic [31:0] adr_i, // address
    input wire logic [3:0] sel_i, // lanes
    input wire logic [31:0] dat_i, // write data
    input wire logic [31:0] dat_o, // read data
    input wire logic ack_o, // acknowledge
    input wire logic [NUM_PINS-1:0] pad_oe_o, // drive enables
    input wire logic analog_pad_enable_i, // analog enable
    input wire logic pll_filter_connect_o, // filter connect
    input wire logic bandgap_test_o // bandgap test
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence bus_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    // filter pin register is word 0xA0BF; its outputs settle two edges after the write
    sequence filt_write;
        bus_req ##0 (we_i && sel_i[0] && adr_i == 32'h0002_82FC);
    endsequence
    chk_ack_follows: assert property (bus_req |=> ack_o)
        else $error("request not acknowledged next cycle");
    chk_ack_single: assert property (ack_o |=> !ack_o)
        else $error("acknowledge longer than one cycle");
    chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("acknowledge without request");
    chk_read_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0)
        else $error("read data above the byte not zero");
    chk_write_data_zero: assert property (ack_o && $past(we_i) |-> dat_o == 32'h0)
        else $error("write answered with data");
    chk_bandgap_set: assert property (filt_write |-> ##2 bandgap_test_o == $past(dat_i[6], 2))
        else $error("bandgap enable does not follow its bit");
    chk_filter_gated: assert property (pll_filter_connect_o |-> $past(analog_pad_enable_i))
        else $error("filter connected without analog enable");
    chk_reset_quiet: assert property ($fell(rst_i) |-> pad_oe_o == '0 && !bandgap_test_o)
        else $error("pin driven straight after reset");
endmodule // pin_func_checker

bind pin_func_mux pin_func_checker i_pin_func_checker (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pad_oe_o(pad_oe_o),
    .analog_pad_enable_i(analog_pad_enable_i), .pll_filter_connect_o(pll_filter_connect_o),
    .bandgap_test_o(bandgap_test_o));

//--- pin_func_mux.sv
// ****************************************************************
// port 5 / port 6 pin function multiplexer
// ****************************************************************
module pin_func_mux
    import pin_func_pkg::*;
(
    input wire logic clk_i, // system clock
    input wire logic rst_i, // synchronous reset, active high
    // wishbone classic slave
    input wire logic cyc_i, // bus cycle
    input wire logic stb_i, // strobe
    input wire logic we_i, // write enable
    input wire logic [31:0] adr_i, // byte address
    input wire logic [3:0] sel_i, // byte lane selects
    input wire logic [31:0] dat_i, // write data
    output logic [31:0] dat_o, // read data
    output logic ack_o, // acknowledge
    // pads: index 0-7 port 5, 8-15 port 6
    input wire logic [NUM_PINS-1:0] pad_i, // pad input level, asynchronous
    output logic [NUM_PINS-1:0] pad_o, // pad output value
    output logic [NUM_PINS-1:0] pad_oe_o, // pad output enable, high drives
    // general-purpose I/O
    input wire logic [NUM_PINS-1:0] gpio_out_i, // gpio output value
    input wire logic [NUM_PINS-1:0] gpio_oe_i, // gpio output enable
    output logic [NUM_PINS-1:0] gpio_in_o, // synchronised pad level to gpio
    // LED controller
    input wire logic digit_drive_mode_flag_i, // 1 selects digit / d-segment drive
    input wire logic [31:0] led_seg_i, // LED segment drive
    input wire logic [15:0] led_dig_i, // LED digit drive
    input wire logic [7:0] led_com_i, // LED common drive
    input wire logic [7:0] led_dseg_i, // LED d-segment drive
    // SPI
    input wire logic spi_mosi_out_i, // MOSI drive value
    input wire logic spi_mosi_oe_i, // MOSI drive enable
    input wire logic spi_miso_out_i, // MISO drive value
    input wire logic spi_miso_oe_i, // MISO drive enable
    input wire logic spi_sck_out_i, // SCK drive value
    input wire logic spi_sck_oe_i, // SCK drive enable
    input wire logic spi_ssn_out_i, // select drive value
    input wire logic spi_ssn_oe_i, // select drive enable
    output logic spi_mosi_in_o, // MOSI level seen on pin
    output logic spi_miso_in_o, // MISO level seen on pin
    output logic spi_sck_in_o, // SCK level seen on pin
    output logic spi_ssn_in_o, // select level seen on pin, idles high
    // capture/compare channels
    input wire logic [5:0] capcomp_out_i, // channel drive values
    input wire logic [5:0] capcomp_oe_i, // channel drive enables
    output logic [5:0] capcomp_in_o, // channel levels seen on pins
    // other peripherals
    output logic timer_two_in_o, // timer 2 external input
    input wire logic buzzer_i, // buzzer waveform
    input wire logic pulse_width_a_i, // pwm a output
    input wire logic pulse_width_b_i, // pwm b output
    input wire logic uart_b_tx_i, // uart b transmit
    input wire logic uart_c_tx_i, // uart c transmit
    input wire logic uart_d_tx_i, // uart d transmit
    output logic uart_b_rx_o, // uart b receive, idles high
    output logic uart_c_rx_o, // uart c receive, idles high
    output logic uart_d_rx_o, // uart d receive, idles high
    input wire logic clock_out_i, // clock to present on a pin
    // analog paths of port 6 pin 7
    input wire logic analog_pad_enable_i, // analog enable of port 6 pin 7
    output logic pll_filter_connect_o, // connect pad to PLL filter
    output logic bandgap_test_o // enable bandgap test path
);

    // ****************************************************************
    // state
    // ****************************************************************
    logic [7:0] cfg_q [NUM_PINS];
    logic [7:0] cfg_d [NUM_PINS];
    logic ack_q, ack_d;
    logic [31:0] dat_q, dat_d;
    logic [NUM_PINS-1:0] pad_meta_q, pad_meta_d;
    logic [NUM_PINS-1:0] pad_sync_q, pad_sync_d;
    logic [NUM_PINS-1:0] pad_out_q, pad_out_d;
    logic [NUM_PINS-1:0] pad_oe_q, pad_oe_d;
    logic [NUM_PINS-1:0] gpio_in_q, gpio_in_d;
    logic [NUM_SRC-1:0] route_in_q, route_in_d;
    logic pll_q, pll_d;
    logic bg_q, bg_d;

    logic [SRC_W-1:0] sel_code [NUM_PINS];
    logic [NUM_SRC-1:0] src_out;
    logic [NUM_SRC-1:0] src_oe;
    logic [NUM_PINS-1:0] reg_hit;
    logic req;

    // writable mask follows from the function map: no function, no storage
    function automatic logic [7:0] cfg_mask(input int pin);
        logic [7:0] m;
        m = 8'h00;
        for (int b = 0; b < 8; b++) begin
            m[b] = (FUNC_MAP[pin][b] != S_NONE);
        end
        return m;
    endfunction

    // receive lines and the SPI select idle high when no pin feeds them
    function automatic logic idle_level(input logic [SRC_W-1:0] code);
        return (code == S_UBRX) || (code == S_UCRX) || (code == S_UDRX) || (code == S_SSN);
    endfunction

    // ****************************************************************
    // wishbone register access
    // ****************************************************************
    assign req = cyc_i && stb_i && !ack_q;

    always_comb begin
        for (int p = 0; p < NUM_PINS; p++) begin
            reg_hit[p] = (adr_i[1:0] == 2'h0) && (adr_i[31:18] == 14'h0000)
                && (adr_i[17:2] == CFG_INDEX[p]);
        end
    end

    always_comb begin
        ack_d = req;
        dat_d = 32'h0000_0000;
        for (int p = 0; p < NUM_PINS; p++) begin
            cfg_d[p] = cfg_q[p];
            if (req && reg_hit[p]) begin
                if (we_i && sel_i[0]) begin
                    cfg_d[p] = dat_i[7:0] & cfg_mask(p);
                end
                if (!we_i) begin
                    dat_d = {24'h00_0000, cfg_q[p]};
                end
            end
        end
    end

    // ****************************************************************
    // function selection per pin
    // ****************************************************************
    // later, higher bits override lower ones: bit 7 wins, gpio is last
    always_comb begin
        for (int p = 0; p < NUM_PINS; p++) begin
            sel_code[p] = S_NONE;
            for (int b = 0; b < 8; b++) begin
                if (cfg_q[p][b] && (FUNC_MAP[p][b] != S_NONE)) begin
                    sel_code[p] = FUNC_MAP[p][b];
                end
            end
        end
    end

    // ****************************************************************
    // peripheral drive sources
    // ****************************************************************
    always_comb begin
        src_out = '0;
        src_oe = '0;
        // LED pins are push-pull whenever selected
        src_out[S_SEGDIG8] = digit_drive_mode_flag_i ? led_dig_i[8] : led_seg_i[8];
        src_out[S_SEGDIG10] = digit_drive_mode_flag_i ? led_dig_i[10] : led_seg_i[10];
        src_out[S_SEGDIG12] = digit_drive_mode_flag_i ? led_dig_i[12] : led_seg_i[12];
        src_oe[S_SEGDIG8] = 1'b1;
        src_oe[S_SEGDIG10] = 1'b1;
        src_oe[S_SEGDIG12] = 1'b1;
        for (int k = 0; k < 8; k++) begin
            src_out[int'(S_COMD0) + k] = digit_drive_mode_flag_i ? led_dseg_i[k] : led_com_i[k];
            src_oe[int'(S_COMD0) + k] = 1'b1;
            src_out[int'(S_SEG24) + k] = led_seg_i[24 + k];
            src_oe[int'(S_SEG24) + k] = 1'b1;
        end
        src_out[S_MOSI] = spi_mosi_out_i;
        src_oe[S_MOSI] = spi_mosi_oe_i;
        src_out[S_MISO] = spi_miso_out_i;
        src_oe[S_MISO] = spi_miso_oe_i;
        src_out[S_SCK] = spi_sck_out_i;
        src_oe[S_SCK] = spi_sck_oe_i;
        src_out[S_SSN] = spi_ssn_out_i;
        src_oe[S_SSN] = spi_ssn_oe_i;
        for (int c = 0; c < 6; c++) begin
            src_out[int'(S_CEX0) + c] = capcomp_out_i[c];
            src_oe[int'(S_CEX0) + c] = capcomp_oe_i[c];
        end
        src_out[S_BUZ] = buzzer_i;
        src_oe[S_BUZ] = 1'b1;
        src_out[S_PWMA] = pulse_width_a_i;
        src_oe[S_PWMA] = 1'b1;
        src_out[S_PWMB] = pulse_width_b_i;
        src_oe[S_PWMB] = 1'b1;
        src_out[S_UBTX] = uart_b_tx_i;
        src_oe[S_UBTX] = 1'b1;
        src_out[S_UCTX] = uart_c_tx_i;
        src_oe[S_UCTX] = 1'b1;
        src_out[S_UDTX] = uart_d_tx_i;
        src_oe[S_UDTX] = 1'b1;
        src_out[S_CLKO] = clock_out_i;
        src_oe[S_CLKO] = 1'b1;
        // timer 2, receive lines, PLL and bandgap leave the digital driver off
    end

    // ****************************************************************
    // pad drive, input routing and analog controls
    // ****************************************************************
    always_comb begin
        pad_meta_d = pad_i;
        pad_sync_d = pad_meta_q;
        for (int p = 0; p < NUM_PINS; p++) begin
            if (sel_code[p] == S_GPIO) begin
                pad_out_d[p] = gpio_out_i[p];
                pad_oe_d[p] = gpio_oe_i[p];
            end else begin
                pad_out_d[p] = src_out[sel_code[p]];
                pad_oe_d[p] = src_oe[sel_code[p]];
            end
            gpio_in_d[p] = cfg_q[p][CFG_GPIO_BIT[2:0]] && pad_sync_q[p];
        end
        for (int c = 0; c < NUM_SRC; c++) begin
            route_in_d[c] = idle_level(SRC_W'(c));
        end
        // walk downward so the lowest pin index wins a shared input
        for (int p = NUM_PINS - 1; p >= 0; p--) begin
            if (sel_code[p] > S_GPIO) begin
                route_in_d[sel_code[p]] = pad_sync_q[p];
            end
        end
        // the pad only reaches the filter when its analog enable is set too
        pll_d = (sel_code[P67_PIN] == S_PLL) && analog_pad_enable_i;
        bg_d = cfg_q[P67_PIN][P67_BANDGAP_BIT[2:0]];
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int p = 0; p < NUM_PINS; p++) begin
                cfg_q[p] <= CFG_RESET;
            end
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
            pad_meta_q <= '0;
            pad_sync_q <= '0;
            pad_out_q <= '0;
            pad_oe_q <= '0;
            gpio_in_q <= '0;
            route_in_q <= '0;
            pll_q <= 1'b0;
            bg_q <= 1'b0;
        end else begin
            for (int p = 0; p < NUM_PINS; p++) begin
                cfg_q[p] <= cfg_d[p];
            end
            ack_q <= ack_d;
            dat_q <= dat_d;
            pad_meta_q <= pad_meta_d;
            pad_sync_q <= pad_sync_d;
            pad_out_q <= pad_out_d;
            pad_oe_q <= pad_oe_d;
            gpio_in_q <= gpio_in_d;
            route_in_q <= route_in_d;
            pll_q <= pll_d;
            bg_q <= bg_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign ack_o = ack_q;
    assign dat_o = dat_q;
    assign pad_o = pad_out_q;
    assign pad_oe_o = pad_oe_q;
    assign gpio_in_o = gpio_in_q;
    assign spi_mosi_in_o = route_in_q[S_MOSI];
    assign spi_miso_in_o = route_in_q[S_MISO];
    assign spi_sck_in_o = route_in_q[S_SCK];
    assign spi_ssn_in_o = route_in_q[S_SSN];
    assign capcomp_in_o = route_in_q[S_CEX5:S_CEX0];
    assign timer_two_in_o = route_in_q[S_T2];
    assign uart_b_rx_o = route_in_q[S_UBRX];
    assign uart_c_rx_o = route_in_q[S_UCRX];
    assign uart_d_rx_o = route_in_q[S_UDRX];
    assign pll_filter_connect_o = pll_q;
    assign bandgap_test_o = bg_q;

endmodule // pin_func_mux

//--- pin_func_pkg.sv
package pin_func_pkg;

    localparam int NUM_PINS = 16;
    localparam int SRC_W = 6;
    localparam int NUM_SRC = 44;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] CFG_GPIO_BIT = 8'h00;
    localparam logic [7:0] P67_PLL_BIT = 8'h07;
    localparam logic [7:0] P67_BANDGAP_BIT = 8'h06;
    localparam int P67_PIN = 15;

    // register index; byte address on the bus is four times the index
    localparam logic [15:0] CFG_INDEX [NUM_PINS] = '{
        16'hA0D8, 16'hA0D9, 16'hA0DA, 16'hA0DB, 16'hA0DC, 16'hA0DD, 16'hA0DE, 16'hA0DF,
        16'hA0B8, 16'hA0B9, 16'hA0BA, 16'hA0BB, 16'hA0BC, 16'hA0BD, 16'hA0BE, 16'hA0BF};

    // pin function source codes
    localparam logic [SRC_W-1:0] S_NONE = 6'h00, S_GPIO = 6'h01,
        S_SEGDIG8 = 6'h02, S_SEGDIG10 = 6'h03, S_SEGDIG12 = 6'h04, S_COMD0 = 6'h05,
        S_COMD1 = 6'h06, S_COMD2 = 6'h07, S_COMD3 = 6'h08, S_COMD4 = 6'h09,
        S_COMD5 = 6'h0A, S_COMD6 = 6'h0B, S_COMD7 = 6'h0C, S_SEG24 = 6'h0D,
        S_SEG25 = 6'h0E, S_SEG26 = 6'h0F, S_SEG27 = 6'h10, S_SEG28 = 6'h11,
        S_SEG29 = 6'h12, S_SEG30 = 6'h13, S_SEG31 = 6'h14, S_MOSI = 6'h15,
        S_MISO = 6'h16, S_SCK = 6'h17, S_SSN = 6'h18, S_T2 = 6'h19, S_CEX0 = 6'h1A,
        S_CEX1 = 6'h1B, S_CEX2 = 6'h1C, S_CEX3 = 6'h1D, S_CEX4 = 6'h1E,
        S_CEX5 = 6'h1F, S_BUZ = 6'h20, S_PWMA = 6'h21, S_PWMB = 6'h22,
        S_UBTX = 6'h23, S_UBRX = 6'h24, S_UCTX = 6'h25, S_UCRX = 6'h26,
        S_UDTX = 6'h27, S_UDRX = 6'h28, S_CLKO = 6'h29, S_PLL = 6'h2A, S_BG = 6'h2B;

    // per pin, bits 7 down to 0; S_NONE marks an unused bit
    localparam logic [7:0][SRC_W-1:0] FUNC_MAP [NUM_PINS] = '{
        {S_SEGDIG8, S_NONE, S_NONE, S_MOSI, S_NONE, S_NONE, S_NONE, S_GPIO},
        {S_SEGDIG10, S_NONE, S_NONE, S_MISO, S_NONE, S_NONE, S_NONE, S_GPIO},
        {S_SEGDIG12, S_NONE, S_NONE, S_T2, S_SCK, S_NONE, S_NONE, S_GPIO},
        {S_COMD0, S_NONE, S_NONE, S_NONE, S_NONE, S_NONE, S_NONE, S_GPIO},
        {S_COMD1, S_NONE, S_NONE, S_NONE, S_NONE, S_NONE, S_NONE, S_GPIO},
        {S_COMD2, S_NONE, S_NONE, S_NONE, S_NONE, S_NONE, S_NONE, S_GPIO},
        {S_COMD3, S_NONE, S_NONE, S_NONE, S_NONE, S_NONE, S_NONE, S_GPIO},
        {S_COMD4, S_SEG31, S_NONE, S_NONE, S_NONE, S_NONE, S_NONE, S_GPIO},
        {S_COMD5, S_SEG30, S_UBRX, S_CEX5, S_BUZ, S_NONE, S_NONE, S_GPIO},
        {S_COMD6, S_SEG29, S_UBTX, S_CEX4, S_PWMA, S_NONE, S_NONE, S_GPIO},
        {S_COMD7, S_SEG28, S_SSN, S_CEX3, S_PWMB, S_NONE, S_NONE, S_GPIO},
        {S_SEG27, S_BUZ, S_UBRX, S_CEX2, S_MISO, S_UDTX, S_UDRX, S_GPIO},
        {S_SEG26, S_PWMB, S_UBTX, S_CEX1, S_MOSI, S_UCTX, S_UCRX, S_GPIO},
        {S_SEG25, S_PWMA, S_BUZ, S_CEX0, S_SCK, S_UDTX, S_UDRX, S_GPIO},
        {S_SEG24, S_UCTX, S_UCRX, S_CLKO, S_SSN, S_UDTX, S_UDRX, S_GPIO},
        {S_PLL, S_BG, S_NONE, S_NONE, S_NONE, S_NONE, S_NONE, S_GPIO}};

endpackage

//--- port5_port6_pin_function_mux_tb_top.sv
// ****************************************
// pin function multiplexer testbench
// ****************************************
module port5_port6_pin_function_mux_tb_top
    import pin_func_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
    logic mode = 1'h0, shuffle = 1'h0;
    logic [31:0] adr_i = 32'h0, dat_i = 32'h0;
    logic [3:0] sel_i = 4'h0;
    logic [15:0] pad_i = 16'h0;
    logic [31:0] dat_o, led_seg, rd;
    logic ack_o, pll_o, bg_o, analog, miso_in, t2, ubrx, ucrx, udrx, oe, vl;
    logic mosi_in, sck_in, ssn_in;
    logic [15:0] pad_o, pad_oe_o, gpio_in, gpio_out, gpio_oe, led_dig;
    logic [7:0] led_com, led_dseg, spi, d;
    logic [5:0] cc_out, cc_oe, cc_in;
    logic [6:0] misc;
    logic [9:0] ins;
    logic [127:0] drv;
    logic [27:0] e;
    int p, fails = 0, tests_run = 0;
    // drive index: 127 is a constant one, 126 a constant zero
    assign drv = {1'h1, 32'h0, gpio_oe[15], gpio_out[15], gpio_oe[0], gpio_out[0], misc, spi,
        cc_oe, cc_out, led_dseg, led_com, led_dig, led_seg};
    assign ins = {sck_in, mosi_in, gpio_in[0], cc_in[5], miso_in, t2, ssn_in, udrx, ucrx, ubrx};
    // digit mode, pin, bit (F sets every bit), value index, enable index
    // the filter entry stands twice: the analog enable alternates between the two
    localparam logic [27:0] OUT_TAB [53] = '{
        28'h007087F, 28'h107287F, 28'h1272C7F, 28'h0044C4D, 28'h0144E4F, 28'h0235051,
        28'h024007E, 28'h037307F, 28'h1673B7F, 28'h077347F, 28'h1773C7F, 28'h1761F7F,
        28'h087357F, 28'h0861E7F, 28'h085007E, 28'h084454B, 28'h083547F, 28'h1973E7F,
        28'h0961D7F, 28'h095577F, 28'h094444A, 28'h093557F, 28'h0A7377F, 28'h0A61C7F,
        28'h0A55253, 28'h0A44349, 28'h0A3567F, 28'h0B71B7F, 28'h0B6547F, 28'h0B44248,
        28'h0B34E4F, 28'h0B2597F, 28'h0C71A7F, 28'h0C44147, 28'h0C2587F, 28'h0D7197F,
        28'h0D5547F, 28'h0D44046, 28'h0D35051, 28'h0E7187F, 28'h0E45A7F, 28'h0E35253,
        28'h0F7007E, 28'h0F7007E, 28'h0F6007E, 28'h0005B5C, 28'h0F05D5E, 28'h09F367F,
        28'h0DF197F, 28'h0170A7F, 28'h1172A7F, 28'h147397F, 28'h057327F};
    // pin, bit, index into ins; indices below 4 idle high
    localparam logic [11:0] IN_TAB [10] = '{12'h850, 12'hE51, 12'hB12, 12'hA53, 12'h244,
        12'h145, 12'h846, 12'h007, 12'h048, 12'h239};
    localparam logic [7:0] MASK [16] = '{8'h91, 8'h91, 8'h99, 8'h81, 8'h81, 8'h81, 8'h81,
        8'hC1, 8'hF9, 8'hF9, 8'hF9, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hC1};
    pin_func_mux i_pin_func_mux (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .pad_i(pad_i), .pad_o(pad_o), .pad_oe_o(pad_oe_o), .gpio_out_i(gpio_out),
        .gpio_oe_i(gpio_oe), .gpio_in_o(gpio_in), .digit_drive_mode_flag_i(mode),
        .led_seg_i(led_seg), .led_dig_i(led_dig), .led_com_i(led_com), .led_dseg_i(led_dseg),
        .spi_mosi_out_i(spi[0]), .spi_mosi_oe_i(spi[1]), .spi_miso_out_i(spi[2]),
        .spi_miso_oe_i(spi[3]), .spi_sck_out_i(spi[4]), .spi_sck_oe_i(spi[5]),
        .spi_ssn_out_i(spi[6]), .spi_ssn_oe_i(spi[7]), .spi_mosi_in_o(mosi_in),
        .spi_miso_in_o(miso_in), .spi_sck_in_o(sck_in), .spi_ssn_in_o(ssn_in),
        .capcomp_out_i(cc_out),
        .capcomp_oe_i(cc_oe), .capcomp_in_o(cc_in), .timer_two_in_o(t2), .buzzer_i(misc[0]),
        .pulse_width_a_i(misc[1]), .pulse_width_b_i(misc[2]), .uart_b_tx_i(misc[3]),
        .uart_c_tx_i(misc[4]), .uart_d_tx_i(misc[5]), .uart_b_rx_o(ubrx), .uart_c_rx_o(ucrx),
        .uart_d_rx_o(udrx), .clock_out_i(misc[6]), .analog_pad_enable_i(analog),
        .pll_filter_connect_o(pll_o), .bandgap_test_o(bg_o));
    periph_drive_model i_periph_drive_model (.clk_i(clk_i), .shuffle_i(shuffle),
        .led_seg_o(led_seg), .led_dig_o(led_dig), .led_com_o(led_com), .led_dseg_o(led_dseg),
        .spi_o(spi), .cc_out_o(cc_out), .cc_oe_o(cc_oe), .misc_o(misc), .gpio_out_o(gpio_out),
        .gpio_oe_o(gpio_oe), .analog_o(analog));
    always #2 clk_i = ~clk_i;
    function automatic logic [31:0] addr_of(input int n);
        return {14'h0, (n < 8 ? 16'hA0D8 : 16'hA0B0) + 16'(n), 2'h0};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] wd,
        input logic [3:0] s);
        int n = 0;
        {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'h3, w, a, 24'h0, wd, s};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'h1 && n < 20);
        rd = dat_o;
        if (n >= 20) check(32'h0, 32'h1, "no acknowledge");
        {cyc_i, stb_i} <= 2'h0;
        @(posedge clk_i);
    endtask
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(32'h4999));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        for (int i = 0; i < 16; i++) begin
            bus(1'h0, addr_of(i), 8'h0, 4'hF);
            check(rd, 32'h0, "reset value");
        end
        $display("test reset values done");
        // misaligned, lane-less and out-of-range writes must all bounce off
        for (int i = 0; i < 16; i++) begin
            d = 8'($urandom);
            bus(1'h1, addr_of(i), d, 4'hF);
            bus(1'h1, addr_of(i) + 32'h1, ~d, 4'hF);
            bus(1'h1, addr_of(i), ~d, 4'hE);
            bus(1'h1, addr_of(i) | 32'h0004_0000, ~d, 4'hF);
            bus(1'h0, addr_of(i), 8'h0, 4'hF);
            check(rd, {24'h0, d & MASK[i]}, "read back");
            bus(1'h0, addr_of(i) | 32'h0004_0000, 8'h0, 4'hF);
            check(rd, 32'h0, "unmapped read");
            bus(1'h1, addr_of(i), 8'h0, 4'hF);
        end
        $display("test register access done");
        for (int i = 0; i < 53; i++) begin
            e = OUT_TAB[i];
            p = int'(e[23:20]);
            mode <= e[24];
            shuffle <= 1'h1;
            bus(1'h1, addr_of(p), (e[19:16] == 4'hF) ? 8'hFF : 8'h1 << e[18:16], 4'hF);
            shuffle <= 1'h0;
            repeat (3) @(posedge clk_i);
            oe = drv[e[6:0]];
            vl = drv[e[14:8]];
            check(32'(pad_oe_o[p]), 32'(oe), "enable");
            if (oe === 1'h1)
                check(32'(pad_o[p]), 32'(vl), "value");
            check(32'(bg_o), 32'(p == 15 && e[18:16] == 3'h6), "bandgap");
            check(32'(pll_o), 32'(p == 15 && e[18:16] == 3'h7 && analog), "filter");
            bus(1'h1, addr_of(p), 8'h0, 4'hF);
        end
        $display("test output routing done");
        for (int i = 0; i < 10; i++) begin
            p = int'(IN_TAB[i][11:8]);
            bus(1'h1, addr_of(p), 8'h1 << IN_TAB[i][7:4], 4'hF);
            for (int lv = 0; lv < 2; lv++) begin
                pad_i[p] <= lv[0];
                repeat (4) @(posedge clk_i);
                check(32'(ins[IN_TAB[i][3:0]]), 32'(lv[0]), "input");
            end
            // park the pad opposite the idle level so a route left open shows up
            vl = (IN_TAB[i][3:0] < 4'h4);
            pad_i[p] <= ~vl;
            bus(1'h1, addr_of(p), 8'h0, 4'hF);
            repeat (3) @(posedge clk_i);
            check(32'(ins[IN_TAB[i][3:0]]), 32'(vl), "idle");
        end
        $display("test input routing done");
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        $display("ERROR %0t: watchdog expired", $time);
        finish_test();
    end
endmodule // port5_port6_pin_function_mux_tb_top
